// [rtl/rsq_top.sv]
// Reset sequencer, boot strap latch and interrupt width checks
`timescale 1ns/1ps
`include "rsq_defs.svh"
module rsq_top
  import rsq_pkg::*;
#(
  parameter int E_CYC = `RSQ_E_CYC,
  parameter int EXT_CH = 4
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic hw_reset_n,
  input wire logic host_soft_restart,
  input wire logic emu_reset_req,
  input wire logic pci_bus_reset_in,
  input wire logic pci_enable_strap,
  input wire logic serial_port2_enable_strap,
  input wire logic hold_in,
  input wire logic [3:0] memif_address_bus,
  input wire logic byte_order_strap,
  input wire logic pci_eeprom_autoinit_strap,
  input wire logic host_data_bit5_strap,
  input wire logic nmi_pin,
  input wire logic [EXT_CH-1:0] external_irq_pin,
  output logic core_reset_reg,
  output logic pci_sm_reset_reg,
  output rsq_boot_t boot_cfg_reg,
  output rsq_pin_en_t pin_en_reg,
  output logic hold_ack_high_grp_reg,
  output logic eeprom_pins_general_reg,
  output logic memif_clk_sync_reg,
  output logic nmi_event_reg,
  output logic nmi_width_err_reg,
  output logic [EXT_CH-1:0] ext_irq_event_reg,
  output logic [EXT_CH-1:0] ext_width_err_reg
);
  localparam int NSYNC = 14;
  localparam int FALL_MIN = `RSQ_ZHZ_FALL_MIN_E * E_CYC;
  localparam int FALL_MAX = `RSQ_ZHZ_FALL_MAX_P
    + `RSQ_ZHZ_FALL_MAX_E * E_CYC;
  localparam int ZV_MIN = `RSQ_ZV_RISE_MIN_E * E_CYC;
  localparam int EMIF_MAX = `RSQ_EMIF_MAX_P + `RSQ_EMIF_MAX_E * E_CYC;
  localparam int LOW_MAX = `RSQ_LOW_RISE_MAX_P;
  localparam int GEN_MIN = `RSQ_GEN_RISE_MIN_P;
  localparam int CW = 10;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  logic rst_lvl;
  logic soft_req;
  logic pci_rst_s;
  logic pci_en_s;
  logic sp2_s;
  logic hold_s;
  rsq_boot_t boot_s;
  logic nmi_s;
  logic [EXT_CH-1:0] ext_s;
  logic [EXT_CH-1:0] ext_pulse;
  logic [EXT_CH-1:0] ext_err;
  logic nmi_pulse;
  logic nmi_err;
  logic hw_n_last_reg;
  logic soft_last_reg;
  logic any_reset;
  logic fall_hw;
  logic rise_hw;
  logic soft_rise;
  logic warm_active_reg;
  logic in_reset;
  logic in_reset_last_reg;
  logic [CW-1:0] fall_cnt_reg;
  logic [CW-1:0] rise_cnt_reg;
  rsq_state_t state_reg;

  assign raw_in = {hw_reset_n, host_soft_restart, emu_reset_req,
                   pci_bus_reset_in, pci_enable_strap,
                   serial_port2_enable_strap, hold_in,
                   memif_address_bus, byte_order_strap,
                   pci_eeprom_autoinit_strap, host_data_bit5_strap};

  rsq_sync #(.WIDTH(NSYNC)) u_sync_ctl (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .async_in(raw_in),
    .sync_out(syn)
  );

  // Interrupt pins idle high, so their synchroniser resets high
  rsq_sync #(.WIDTH(EXT_CH + 1), .RST_VAL('1)) u_sync_irq (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .async_in({nmi_pin, external_irq_pin}),
    .sync_out({nmi_s, ext_s})
  );

  // Synchronised control and strap fields
  assign rst_lvl = syn[13];
  assign soft_req = syn[12] | syn[11];
  assign pci_rst_s = syn[10];
  assign pci_en_s = syn[9];
  assign sp2_s = syn[8];
  assign hold_s = syn[7];
  assign boot_s = syn[6:0];

  assign fall_hw = hw_n_last_reg & ~rst_lvl;
  assign rise_hw = ~hw_n_last_reg & rst_lvl;
  assign soft_rise = pci_en_s & soft_req & ~soft_last_reg;
  assign in_reset = ~rst_lvl | warm_active_reg;
  assign any_reset = in_reset & ~in_reset_last_reg;

  // Edge history
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hw_n_last_reg <= 1'b0;
      soft_last_reg <= 1'b0;
      in_reset_last_reg <= 1'b1;
    end else if (clk_en) begin
      hw_n_last_reg <= rst_lvl;
      soft_last_reg <= soft_req;
      in_reset_last_reg <= in_reset;
    end
  end

  // Warm restart, taken only with the PCI enable strap set, holds the core in reset while requested
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      warm_active_reg <= 1'b0;
    end else if (clk_en) begin
      if (soft_rise)
        warm_active_reg <= 1'b1;
      else if (!soft_req)
        warm_active_reg <= 1'b0;
    end
  end

  // Core reset follows hardware or warm reset, never the PCI one
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      core_reset_reg <= 1'b1;
      pci_sm_reset_reg <= 1'b1;
    end else if (clk_en) begin
      core_reset_reg <= in_reset;
      pci_sm_reset_reg <= pci_rst_s;
    end
  end

  // Boot straps latched only on hardware reset release
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      boot_cfg_reg <= '0;
    end else if (clk_en && rise_hw) begin
      boot_cfg_reg <= boot_s;
    end
  end

  // Phase counters since reset entry and since release
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= RSQ_ST_RESET;
      fall_cnt_reg <= '0;
      rise_cnt_reg <= '0;
    end else if (clk_en) begin
      case (state_reg)
        RSQ_ST_IDLE, RSQ_ST_RUN: begin
          if (any_reset) begin
            state_reg <= RSQ_ST_RESET;
            fall_cnt_reg <= '0;
          end
        end
        RSQ_ST_RESET: begin
          if (fall_cnt_reg != '1)
            fall_cnt_reg <= fall_cnt_reg + 10'h001;
          if (!in_reset) begin
            state_reg <= RSQ_ST_RELEASE;
            rise_cnt_reg <= '0;
          end
        end
        RSQ_ST_RELEASE: begin
          if (in_reset) begin
            state_reg <= RSQ_ST_RESET;
            fall_cnt_reg <= '0;
          end else if (rise_cnt_reg >= CW'(ZV_MIN)) begin
            state_reg <= RSQ_ST_RUN;
          end else begin
            rise_cnt_reg <= rise_cnt_reg + 10'h001;
          end
        end
        default: state_reg <= RSQ_ST_RESET;
      endcase
    end
  end

  // Pin group enables
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_en_reg <= '0;
      memif_clk_sync_reg <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        RSQ_ST_RESET: begin
          pin_en_reg.general_oe <= 1'b0;
          pin_en_reg.eeprom_valid <= 1'b0;
          if (fall_cnt_reg >= CW'(FALL_MIN - 1)) begin
            pin_en_reg.memif_clk_oe <= 1'b0;
            pin_en_reg.memif_ctl_valid <= 1'b0;
            pin_en_reg.memif_bus_oe <= 1'b0;
            memif_clk_sync_reg <= 1'b0;
          end
        end
        RSQ_ST_RELEASE: begin
          if (rise_cnt_reg >= CW'(GEN_MIN - 1)) begin
            pin_en_reg.general_oe <= 1'b1;
            pin_en_reg.eeprom_valid <= 1'b1;
            pin_en_reg.memif_clk_oe <= 1'b1;
            pin_en_reg.memif_ctl_valid <= 1'b1;
            memif_clk_sync_reg <= 1'b1;
          end
          if (rise_cnt_reg >= CW'(ZV_MIN - 1))
            pin_en_reg.memif_bus_oe <= 1'b1;
        end
        RSQ_ST_RUN: begin
          pin_en_reg <= '1;
          memif_clk_sync_reg <= 1'b1;
        end
        default: pin_en_reg <= '0;
      endcase
    end
  end

  // Group membership of shared pins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hold_ack_high_grp_reg <= 1'b0;
      eeprom_pins_general_reg <= 1'b1;
    end else if (clk_en) begin
      hold_ack_high_grp_reg <= hold_s;
      eeprom_pins_general_reg <= ~(pci_en_s & ~sp2_s);
    end
  end

  // Non-maskable pin width check
  rsq_pulse_filt #(.CHANNELS(1), .MIN_CYC(`RSQ_NMI_MIN_P)) u_nmi (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .pin_level(nmi_s),
    .irq_pulse(nmi_pulse),
    .width_err(nmi_err)
  );

  // External pin width checks
  rsq_pulse_filt #(.CHANNELS(EXT_CH), .MIN_CYC(`RSQ_EXT_MIN_P)) u_ext (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .pin_level(ext_s),
    .irq_pulse(ext_pulse),
    .width_err(ext_err)
  );

  // Interrupt outputs registered at the top
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      nmi_event_reg <= 1'b0;
      nmi_width_err_reg <= 1'b0;
      ext_irq_event_reg <= '0;
      ext_width_err_reg <= '0;
    end else if (clk_en) begin
      nmi_event_reg <= nmi_pulse & ~core_reset_reg;
      nmi_width_err_reg <= nmi_err;
      ext_irq_event_reg <= ext_pulse & {EXT_CH{~core_reset_reg}};
      ext_width_err_reg <= ext_err;
    end
  end

  logic unused_max;
  assign unused_max = (FALL_MAX > EMIF_MAX) | (LOW_MAX < 0);
endmodule

// [rtl/rsq_defs.svh]
// Constants for the reset and external interrupt sequencer
`ifndef RSQ_DEFS_SVH
`define RSQ_DEFS_SVH
`define RSQ_SYS_CLK_MHZ 100
`define RSQ_P_NS 10
`define RSQ_E_CYC 4
`define RSQ_BOOT_ADDR_HI 22
`define RSQ_BOOT_ADDR_LO 19
`define RSQ_ZHZ_FALL_MIN_E 2
`define RSQ_ZHZ_FALL_MAX_P 3
`define RSQ_ZHZ_FALL_MAX_E 4
`define RSQ_ZV_RISE_MIN_E 16
`define RSQ_EMIF_MAX_P 8
`define RSQ_EMIF_MAX_E 20
`define RSQ_LOW_RISE_MAX_P 11
`define RSQ_GEN_RISE_MIN_P 2
`define RSQ_GEN_RISE_MAX_P 8
`define RSQ_NMI_MIN_P 4
`define RSQ_EXT_MIN_P 8
`define RSQ_CNT_W 8
`endif

// [rtl/rsq_pkg.sv]
// Types for the reset and external interrupt sequencer
package rsq_pkg;
  typedef struct packed {
    logic [3:0] addr_bits;
    logic byte_order;
    logic eeprom_autoinit;
    logic host_bit5;
  } rsq_boot_t;
  typedef struct packed {
    logic memif_bus_oe;
    logic memif_clk_oe;
    logic memif_ctl_valid;
    logic eeprom_valid;
    logic general_oe;
  } rsq_pin_en_t;
  typedef enum logic [1:0] {
    RSQ_ST_IDLE = 2'b00,
    RSQ_ST_RESET = 2'b01,
    RSQ_ST_RELEASE = 2'b10,
    RSQ_ST_RUN = 2'b11
  } rsq_state_t;
endpackage

// [rtl/rsq_sync.sv]
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module rsq_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// [rtl/rsq_pulse_filt.sv]
// Qualifies interrupt pins by least low and high widths
`timescale 1ns/1ps
`include "rsq_defs.svh"
module rsq_pulse_filt #(
  parameter int CHANNELS = 4,
  parameter int MIN_CYC = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [CHANNELS-1:0] pin_level,
  output logic [CHANNELS-1:0] irq_pulse,
  output logic [CHANNELS-1:0] width_err
);
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      logic [`RSQ_CNT_W-1:0] cnt_reg;
      logic last_reg;
      logic low_ok_reg;
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          cnt_reg <= '0;
          last_reg <= 1'b1;
          low_ok_reg <= 1'b0;
          irq_pulse[g] <= 1'b0;
          width_err[g] <= 1'b0;
        end else if (clk_en) begin
          irq_pulse[g] <= 1'b0;
          width_err[g] <= 1'b0;
          last_reg <= pin_level[g];
          if (pin_level[g] != last_reg) begin
            cnt_reg <= 8'h01;
            if (cnt_reg < MIN_CYC[`RSQ_CNT_W-1:0])
              width_err[g] <= 1'b1;
            if (pin_level[g] && low_ok_reg && cnt_reg >=
                MIN_CYC[`RSQ_CNT_W-1:0])
              irq_pulse[g] <= 1'b1;
            low_ok_reg <= 1'b0;
          end else begin
            if (cnt_reg != 8'hFF)
              cnt_reg <= cnt_reg + 8'h01;
            if (!pin_level[g] && cnt_reg >= MIN_CYC[`RSQ_CNT_W-1:0] - 8'h01)
              low_ok_reg <= 1'b1;
          end
        end
      end
    end
  endgenerate
endmodule

// [sim/rsq_top_props.sv]
// Port checker for the reset sequencer
`timescale 1ns/1ps
module rsq_top_props
  import rsq_pkg::*;
#(
  parameter int E_CYC = 4,
  parameter int EXT_CH = 4
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hw_reset_n,
  input wire logic host_soft_restart,
  input wire logic emu_reset_req,
  input wire logic pci_bus_reset_in,
  input wire logic core_reset_reg,
  input wire logic pci_sm_reset_reg,
  input wire rsq_boot_t boot_cfg_reg,
  input wire rsq_pin_en_t pin_en_reg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [7:0] rel_cnt;
  logic [7:0] hw_cnt;
  // Cycles since the last release of hardware, host soft or emulator reset
  always_ff @(posedge sys_clk) begin
    if (srst || !hw_reset_n || host_soft_restart || emu_reset_req)
      rel_cnt <= 8'h00;
    else if (rel_cnt != 8'hFF)
      rel_cnt <= rel_cnt + 8'h01;
  end
  // Cycles since the last hardware reset release
  always_ff @(posedge sys_clk) begin
    if (srst || !hw_reset_n)
      hw_cnt <= 8'h00;
    else if (hw_cnt != 8'hFF)
      hw_cnt <= hw_cnt + 8'h01;
  end
  core_enter_a: assert property ($fell(hw_reset_n) |-> ##[1:5] core_reset_reg)
    else $error("core reset not entered");
  pci_spares_a: assert property ($fell(hw_reset_n) && !pci_sm_reset_reg
    && !pci_bus_reset_in |-> !pci_sm_reset_reg [*8])
    else $error("hardware reset touched pci state");
  core_spared_a: assert property ($rose(pci_bus_reset_in) && hw_reset_n
    && !core_reset_reg && !host_soft_restart && !emu_reset_req
    |-> !core_reset_reg [*6])
    else $error("pci reset touched core");
  bus_float_min_a: assert property ($fell(hw_reset_n) && pin_en_reg.memif_bus_oe
    |-> pin_en_reg.memif_bus_oe [*8])
    else $error("memory bus floated early");
  bus_float_max_a: assert property ($fell(hw_reset_n)
    |-> ##[1:19] !pin_en_reg.memif_bus_oe)
    else $error("memory bus floated late");
  bus_valid_min_a: assert property ($rose(pin_en_reg.memif_bus_oe)
    |-> rel_cnt >= 8'h40)
    else $error("memory bus driven early");
  bus_valid_max_a: assert property (rel_cnt == 8'h58
    |-> pin_en_reg.memif_bus_oe && pin_en_reg.memif_clk_oe
    && pin_en_reg.memif_ctl_valid)
    else $error("memory groups driven late");
  gen_valid_min_a: assert property ($rose(pin_en_reg.general_oe)
    |-> rel_cnt >= 8'h02)
    else $error("general group driven early");
  gen_valid_max_a: assert property (rel_cnt == 8'h08
    |-> pin_en_reg.general_oe)
    else $error("general group driven late");
  eeprom_valid_a: assert property (rel_cnt == 8'h0B
    |-> pin_en_reg.eeprom_valid)
    else $error("eeprom pins valid late");
  boot_hold_a: assert property (!$stable(boot_cfg_reg)
    |-> hw_cnt <= 8'h06)
    else $error("boot config changed outside hardware reset");
endmodule
bind rsq_top rsq_top_props #(.E_CYC(E_CYC), .EXT_CH(EXT_CH)) chk (
  .sys_clk, .srst, .hw_reset_n, .host_soft_restart, .emu_reset_req,
  .pci_bus_reset_in, .core_reset_reg, .pci_sm_reset_reg, .boot_cfg_reg,
  .pin_en_reg);

// [sim/rsq_board.sv]
// Board reset supervisor model driving reset and boot straps
`timescale 1ns/1ps
module rsq_board #(
  parameter int LOW_CYC = 300
) (
  input wire logic sys_clk,
  output logic hw_reset_n,
  output logic [6:0] straps
);
  // Reset low from power-up
  initial begin
    hw_reset_n = 1'b0;
    straps = 7'h00;
  end
  // Scaled-down low time
  task automatic hw_pulse(input logic [6:0] pat);
    @(posedge sys_clk);
    #1 hw_reset_n = 1'b0;
    straps = pat;
    repeat (LOW_CYC) @(posedge sys_clk);
    #1 hw_reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 straps = ~pat;
  endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
module tb_top;
  import rsq_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic host_soft_restart = 1'b0;
  logic emu_reset_req = 1'b0;
  logic pci_bus_reset_in = 1'b0;
  logic pci_enable_strap = 1'b1;
  logic serial_port2_enable_strap = 1'b0;
  logic hold_in = 1'b0;
  logic nmi_pin = 1'b1;
  logic [3:0] external_irq_pin = 4'hF;
  logic hw_reset_n;
  logic [6:0] straps;
  logic core_reset_reg, pci_sm_reset_reg, hold_ack_high_grp_reg;
  logic eeprom_pins_general_reg, memif_clk_sync_reg;
  logic nmi_event_reg, nmi_width_err_reg;
  logic [3:0] ext_irq_event_reg, ext_width_err_reg;
  rsq_boot_t boot_cfg_reg;
  rsq_pin_en_t pin_en_reg;
  int n_errors = 0;
  int compares = 0;
  always #5 sys_clk = ~sys_clk;
  rsq_board board (.sys_clk, .hw_reset_n, .straps);
  rsq_top uut (.sys_clk, .srst, .clk_en, .hw_reset_n, .host_soft_restart,
    .emu_reset_req, .pci_bus_reset_in, .pci_enable_strap,
    .serial_port2_enable_strap, .hold_in,
    .memif_address_bus(straps[6:3]), .byte_order_strap(straps[2]),
    .pci_eeprom_autoinit_strap(straps[1]), .host_data_bit5_strap(straps[0]),
    .nmi_pin, .external_irq_pin, .core_reset_reg, .pci_sm_reset_reg,
    .boot_cfg_reg, .pin_en_reg, .hold_ack_high_grp_reg,
    .eeprom_pins_general_reg, .memif_clk_sync_reg, .nmi_event_reg,
    .nmi_width_err_reg, .ext_irq_event_reg, .ext_width_err_reg);
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic t_cold(input logic [6:0] pat);
    fork
      board.hw_pulse(pat);
      begin
        step(30);
        chk("core_in", 8'h01, 8'(core_reset_reg));
        chk("pins_in", 8'h00, 8'(pin_en_reg));
      end
    join
    step(100);
    chk("core_out", 8'h00, 8'(core_reset_reg));
    chk("pins_out", 8'h1F, 8'(pin_en_reg));
    chk("boot", 8'(pat), 8'(boot_cfg_reg));
    chk("clk_sync", 8'h01, 8'(memif_clk_sync_reg));
  endtask
  task automatic t_warm(input logic sel, input logic [6:0] pat);
    board.straps = ~pat;
    if (sel) emu_reset_req = 1'b1;
    else host_soft_restart = 1'b1;
    step(20);
    chk("warm_core", 8'h01, 8'(core_reset_reg));
    chk("warm_gen", 8'h00, 8'(pin_en_reg.general_oe));
    host_soft_restart = 1'b0;
    emu_reset_req = 1'b0;
    step(100);
    chk("warm_out", 8'h00, 8'(core_reset_reg));
    chk("warm_boot", 8'(pat), 8'(boot_cfg_reg));
  endtask
  task automatic t_pci;
    clk_en = 1'b0;
    pci_bus_reset_in = 1'b1;
    step(8);
    chk("pci_frozen", 8'h00, 8'(pci_sm_reset_reg));
    clk_en = 1'b1;
    step(8);
    chk("pci_sm_on", 8'h01, 8'(pci_sm_reset_reg));
    chk("pci_core", 8'h00, 8'(core_reset_reg));
    pci_bus_reset_in = 1'b0;
    step(8);
    chk("pci_sm_off", 8'h00, 8'(pci_sm_reset_reg));
  endtask
  task automatic t_groups;
    for (int i = 0; i < 2; i++) begin
      serial_port2_enable_strap = 1'(i);
      hold_in = 1'(i);
      step(6);
      chk("eeprom_grp", 8'(i), 8'(eeprom_pins_general_reg));
      chk("hold_grp", 8'(i), 8'(hold_ack_high_grp_reg));
    end
  endtask
  task automatic t_irq(input int ch, input int w, input int ev, input int er);
    int n_ev;
    int n_er;
    n_ev = 0;
    n_er = 0;
    if (ch == 4) nmi_pin = 1'b0;
    else external_irq_pin[ch] = 1'b0;
    step(w);
    nmi_pin = 1'b1;
    external_irq_pin = 4'hF;
    for (int k = 0; k < 30; k++) begin
      step(1);
      n_ev += (ch == 4) ? nmi_event_reg : ext_irq_event_reg[ch];
      n_er += (ch == 4) ? nmi_width_err_reg : ext_width_err_reg[ch];
    end
    chk("irq_event", 8'(ev), 8'(n_ev));
    chk("irq_width_err", 8'(er), 8'(n_er));
  endtask
  task automatic t_gap(input int hi, input int er);
    int n_ev;
    int n_er;
    n_ev = 0;
    n_er = 0;
    for (int k = 0; k < 50; k++) begin
      external_irq_pin[0] = !(k < 8 || (k >= 8 + hi && k < 16 + hi));
      step(1);
      n_ev += ext_irq_event_reg[0];
      n_er += ext_width_err_reg[0];
    end
    chk("gap_event", 8'h02, 8'(n_ev));
    chk("gap_width_err", 8'(er), 8'(n_er));
  endtask
  initial begin
    step(12);
    srst = 1'b0;
    t_cold(7'h5A);
    t_cold(7'h25);
    t_warm(1'b0, 7'h25);
    t_warm(1'b1, 7'h25);
    t_pci();
    t_groups();
    for (int c = 0; c < 4; c++) begin
      t_irq(c, 8, 1, 0);
      t_irq(c, 7, 0, 1);
    end
    t_irq(4, 4, 1, 0);
    t_irq(4, 3, 0, 1);
    t_gap(8, 0);
    t_gap(7, 1);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end
endmodule
